// ### logic/spsu_pkg.sv
// Purpose: Shared constants for the signal label and unequipped supervision block
// Assumes: Byte-wide container stream, overhead at fixed frame positions
// Notes:   Trace check helper lives here so both ends of the design agree
package spsu_pkg;

  // Overhead byte positions inside one container frame
  localparam int unsigned POS_TRACE  = 0;
  localparam int unsigned POS_PARITY = 1;
  localparam int unsigned POS_LABEL  = 2;
  localparam int unsigned POS_STATUS = 3;
  localparam int unsigned POS_OPER   = 4;

  // Label codes
  localparam logic [7:0] LABEL_IDLE_UNEQUIPPED_CONTAINER    = 8'h00;
  localparam logic [7:0] LABEL_NONSPEC = 8'h01;
  localparam logic [7:0] LABEL_AIS     = 8'hff;

  // Trace string layout and check polynomial x^7 + x^3 + 1
  localparam int unsigned TRACE_LEN = 16;
  localparam logic [7:0]  TRACE_HDR = 8'h80;
  localparam logic [6:0]  CRC7_POLY = 7'h09;

  // Output modes of the matrix port
  localparam logic [1:0] MODE_TRAFFIC    = 2'h0;
  localparam logic [1:0] MODE_IDLE       = 2'h1;
  localparam logic [1:0] MODE_SUP_INLINE = 2'h2;
  localparam logic [1:0] MODE_SUP_GROUP  = 2'h3;

  // Register map (word index on the plain port)
  localparam logic [5:0] ADDR_CTRL   = 6'h00;
  localparam logic [5:0] ADDR_STATUS = 6'h01;
  localparam logic [5:0] ADDR_TRACE  = 6'h10;

  // Control fields and reset value
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_EXP_LSB  = 8;
  localparam int unsigned CTRL_SUPK_BIT = 16;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0101;

  // Frames a label must repeat before it is accepted
  localparam int unsigned ACCEPT_FRAMES = 5;

  // Status byte layout: remote error count high nibble, remote defect bit 3
  localparam int unsigned STAT_RDI_BIT = 3;

  // One byte of the trace check, first bit is most significant
  function automatic logic [6:0] crc7_byte(input logic [6:0] crc_in, input logic [7:0] data);
    logic [6:0] c;
    logic       fb;
    c = crc_in;
    for (int i = 7; i >= 0; i--) begin
      fb = c[6] ^ data[i];
      c  = {c[5:0], 1'b0} ^ (fb ? CRC7_POLY : 7'h00);
    end
    return c;
  endfunction

endpackage

// ### logic/spsu_trace_mem.sv
// Purpose: Trace string store, one write port, two registered read ports
// Assumes: Synchronous active-low reset clears contents to zero
// Notes:   Port a feeds the transmitter, port b the background check scan
`timescale 1ns/100ps
`default_nettype none
module spsu_trace_mem #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16,
  parameter int unsigned AW    = 4
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  // Write port
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // Read ports
  input  wire logic [AW-1:0]    rd_addr_a,
  output logic      [WIDTH-1:0] rd_data_a,
  input  wire logic [AW-1:0]    rd_addr_b,
  output logic      [WIDTH-1:0] rd_data_b
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Contents cleared at reset so an unprovisioned trace is all zero
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
      rd_data_a <= '0;
      rd_data_b <= '0;
    end else begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_data_a <= mem[rd_addr_a];
      rd_data_b <= mem[rd_addr_b];
    end
  end

endmodule
`default_nettype wire

// ### logic/spsu_label_sup.sv
// Purpose: Idle/supervisory container source and label supervision sink
// Assumes: Byte stream, traffic input aligned to the local frame counter
// Notes:   Sink flags are refreshed once per received frame
//
// Functional notes
// - Idle container: zero label, trace, operator byte; correct parity.
// - Supervisory container: valid trace, zero label and operator, parity, remote fields.
// - Supervisory container received is classified unequipped like plain idle.
// - While unequipped, suppress trace mismatch and remote defect causes.
// - While unequipped, ignore received remote defect/error for far-end monitoring.
// - Detect disconnection by accepted label equal to code zero.
// - Code zero reports unequipped, never label mismatch.
// - Unconnected matrix output continuously sends idle unequipped container.
// - Absent terminations: virtual outputs carry unequipped containers.
// - In-line option: idle output replaced by supervisory container.
// - Resource-group option: output fed from supervisory source input; here built internally, same as in-line.
// - Compare accepted label with provisioned expected label.
// - Accepted code one matches any expected equipped label.
// - Label evaluated for alarm indication (all ones).
// - Idle link availability from pointer loss and alarm indication.
// - Trace: header MSB one with 7-bit check, 15 bytes MSB zero.
// - Check is remainder of trace times x^7 over x^7+x^3+1.
// - Alarm indication is an all-ones replacement signal.
`timescale 1ns/100ps
`default_nettype none
module spsu_label_sup #(
  parameter int unsigned FRAME_LEN = 16,
  parameter int unsigned ACCEPT_N  = spsu_pkg::ACCEPT_FRAMES
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // Register port
  input  wire logic [5:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Transmit side of the matrix output
  input  wire logic [7:0]  trf_byte,
  output logic      [7:0]  tx_byte,
  output logic             tx_frame_start,
  // Receive side
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_valid,
  input  wire logic        rx_frame_start,
  input  wire logic        pointer_loss_condition,
  input  wire logic        trace_mismatch_raw,
  // Supervision status
  output logic      [7:0]  accepted_label,
  output logic             unequipped_defect,
  output logic             label_mismatch,
  output logic             ais_detect,
  output logic             trace_mismatch_cause,
  output logic             remote_defect_cause,
  output logic      [3:0]  fe_error_count,
  output logic             fe_count_valid,
  output logic             link_available,
  output logic             sup_link_fault
);

  localparam int unsigned PW = $clog2(FRAME_LEN);
  localparam logic [PW-1:0] POS_LAST = PW'(FRAME_LEN - 1);
  localparam int unsigned CW = $clog2(ACCEPT_N + 1);

  // Control register and trace store
  logic [31:0] ctrl;
  logic [31:0] next_ctrl;
  logic [31:0] next_reg_rdata;
  logic [1:0]  mode;
  logic [7:0]  expected_label;
  logic        sup_sink_en;
  logic        mem_wr;
  logic [7:0]  mem_data_a;
  logic [7:0]  mem_data_b;

  assign mode           = ctrl[spsu_pkg::CTRL_MODE_LSB +: 2];
  assign expected_label = ctrl[spsu_pkg::CTRL_EXP_LSB +: 8];
  assign sup_sink_en    = ctrl[spsu_pkg::CTRL_SUPK_BIT];
  assign mem_wr         = reg_wr && (reg_addr[5:4] == spsu_pkg::ADDR_TRACE[5:4]);

  // Transmit state
  logic [PW-1:0] tx_pos;
  logic [PW-1:0] next_tx_pos;
  logic [3:0]    tx_trace_idx;
  logic [3:0]    next_tx_trace_idx;
  logic [7:0]    tx_bip_acc;
  logic [7:0]    next_tx_bip_acc;
  logic [7:0]    tx_bip;
  logic [7:0]    next_tx_bip;
  logic [7:0]    next_tx_byte;
  logic          next_tx_frame_start;

  // Background trace check scan
  logic [3:0]    scan_idx;
  logic [3:0]    scan_prev;
  logic [6:0]    scan_crc;
  logic [6:0]    next_scan_crc;
  logic [6:0]    trace_crc;
  logic [6:0]    next_trace_crc;

  // Receive state
  logic [PW-1:0] rx_pos;
  logic [PW-1:0] next_rx_pos;
  logic [PW-1:0] rx_pos_now;
  logic [7:0]    rx_bip_acc;
  logic [7:0]    next_rx_bip_acc;
  logic [7:0]    rx_bip_prev;
  logic [7:0]    next_rx_bip_prev;
  logic [3:0]    local_err;
  logic [3:0]    next_local_err;
  logic [7:0]    cand_label;
  logic [7:0]    next_cand_label;
  logic [CW-1:0] cand_cnt;
  logic [CW-1:0] next_cand_cnt;
  logic [7:0]    next_accepted_label;
  logic          next_unequipped_defect;
  logic          next_label_mismatch;
  logic          next_ais_detect;
  logic          next_trace_mismatch_cause;
  logic          next_remote_defect_cause;
  logic [3:0]    next_fe_error_count;
  logic          next_fe_count_valid;
  logic          next_link_available;
  logic          next_sup_link_fault;

  spsu_trace_mem #(
    .WIDTH (8),
    .DEPTH (spsu_pkg::TRACE_LEN),
    .AW    (4)
  ) u_trace_mem (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .wr_en     (mem_wr),
    .wr_addr   (reg_addr[3:0]),
    .wr_data   (reg_wdata[7:0]),
    .rd_addr_a (next_tx_trace_idx),
    .rd_data_a (mem_data_a),
    .rd_addr_b (scan_idx),
    .rd_data_b (mem_data_b)
  );

  // Register decode; trace bytes are write-only and read back zero
  always_comb begin
    next_ctrl      = ctrl;
    next_reg_rdata = 32'h0000_0000;
    if (reg_wr && reg_addr == spsu_pkg::ADDR_CTRL) begin
      next_ctrl = reg_wdata;
    end
    if (reg_rd) begin
      case (reg_addr)
        spsu_pkg::ADDR_CTRL:   next_reg_rdata = ctrl;
        spsu_pkg::ADDR_STATUS: next_reg_rdata = {1'b0, trace_crc, accepted_label, 8'h00,
                                                 sup_link_fault, link_available, remote_defect_cause,
                                                 trace_mismatch_cause, ais_detect, label_mismatch,
                                                 unequipped_defect, fe_count_valid};
        default:               next_reg_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ctrl      <= spsu_pkg::CTRL_RESET;
      reg_rdata <= 32'h0000_0000;
    end else begin
      ctrl      <= next_ctrl;
      reg_rdata <= next_reg_rdata;
    end
  end

  // Trace check scan, header taken with check bits zero
  always_comb begin
    logic [7:0] b;
    logic [6:0] seed;
    b              = (scan_prev == 4'h0) ? spsu_pkg::TRACE_HDR : {1'b0, mem_data_b[6:0]};
    seed           = (scan_prev == 4'h0) ? 7'h00 : scan_crc;
    next_scan_crc  = spsu_pkg::crc7_byte(seed, b);
    next_trace_crc = (scan_prev == 4'hf) ? next_scan_crc : trace_crc;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      scan_idx  <= 4'h0;
      scan_prev <= 4'h0;
      scan_crc  <= 7'h00;
      trace_crc <= 7'h00;
    end else begin
      scan_idx  <= scan_idx + 4'h1;
      scan_prev <= scan_idx;
      scan_crc  <= next_scan_crc;
      trace_crc <= next_trace_crc;
    end
  end

  // Transmit byte builder; non-traffic modes replace the matrix output
  always_comb begin
    logic sup;
    logic [7:0] out_b;
    sup   = (mode == spsu_pkg::MODE_SUP_INLINE) || (mode == spsu_pkg::MODE_SUP_GROUP);
    out_b = 8'h00;
    if (mode == spsu_pkg::MODE_TRAFFIC) begin
      out_b = trf_byte;
    end else begin
      case (tx_pos)
        PW'(spsu_pkg::POS_TRACE): begin
          if (sup) begin
            out_b = (tx_trace_idx == 4'h0) ? {1'b1, trace_crc} : {1'b0, mem_data_a[6:0]};
          end else begin
            out_b = 8'h00;
          end
        end
        PW'(spsu_pkg::POS_PARITY): out_b = tx_bip;
        PW'(spsu_pkg::POS_LABEL):  out_b = spsu_pkg::LABEL_IDLE_UNEQUIPPED_CONTAINER;
        PW'(spsu_pkg::POS_STATUS): out_b = sup ? {local_err, ais_detect | pointer_loss_condition, 3'b000}
                                              : 8'h00;
        PW'(spsu_pkg::POS_OPER):   out_b = 8'h00;
        default:                   out_b = 8'h00;
      endcase
    end
    next_tx_byte        = out_b;
    next_tx_frame_start = (tx_pos == '0);
    next_tx_pos         = (tx_pos == POS_LAST) ? '0 : tx_pos + PW'(1);
    next_tx_trace_idx   = (tx_pos == POS_LAST) ? tx_trace_idx + 4'h1 : tx_trace_idx;
    next_tx_bip_acc     = (tx_pos == POS_LAST) ? 8'h00 : tx_bip_acc ^ out_b;
    next_tx_bip         = (tx_pos == POS_LAST) ? tx_bip_acc ^ out_b : tx_bip;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      tx_pos         <= '0;
      tx_trace_idx   <= 4'h0;
      tx_bip_acc     <= 8'h00;
      tx_bip         <= 8'h00;
      tx_byte        <= 8'h00;
      tx_frame_start <= 1'b0;
    end else begin
      tx_pos         <= next_tx_pos;
      tx_trace_idx   <= next_tx_trace_idx;
      tx_bip_acc     <= next_tx_bip_acc;
      tx_bip         <= next_tx_bip;
      tx_byte        <= next_tx_byte;
      tx_frame_start <= next_tx_frame_start;
    end
  end

  // Receive supervision, flags refreshed at each frame start, remote defect and far-end count at the status byte
  assign rx_pos_now = rx_frame_start ? '0 : rx_pos + PW'(1);

  always_comb begin
    logic idle_unequipped_container;
    logic mism;
    logic ais;
    next_rx_pos               = rx_pos;
    next_rx_bip_acc           = rx_bip_acc;
    next_rx_bip_prev          = rx_bip_prev;
    next_local_err            = local_err;
    next_cand_label           = cand_label;
    next_cand_cnt             = cand_cnt;
    next_accepted_label       = accepted_label;
    next_unequipped_defect    = unequipped_defect;
    next_label_mismatch       = label_mismatch;
    next_ais_detect           = ais_detect;
    next_trace_mismatch_cause = trace_mismatch_cause;
    next_remote_defect_cause  = remote_defect_cause;
    next_fe_error_count       = fe_error_count;
    next_fe_count_valid       = 1'b0;
    next_link_available       = link_available;
    next_sup_link_fault       = sup_link_fault;
    idle_unequipped_container = (accepted_label == spsu_pkg::LABEL_IDLE_UNEQUIPPED_CONTAINER);
    ais  = (accepted_label == spsu_pkg::LABEL_AIS);
    mism = !idle_unequipped_container && (accepted_label != expected_label)
           && (accepted_label != spsu_pkg::LABEL_NONSPEC);
    if (rx_valid) begin
      next_rx_pos = (rx_pos_now == POS_LAST) ? POS_LAST : rx_pos_now;
      if (rx_frame_start) begin
        next_rx_bip_acc           = rx_byte;
        next_rx_bip_prev          = rx_bip_acc;
        next_unequipped_defect    = idle_unequipped_container;
        next_label_mismatch       = mism;
        next_ais_detect           = ais;
        next_trace_mismatch_cause = trace_mismatch_raw && !idle_unequipped_container;
        next_link_available       = !pointer_loss_condition && !ais;
        next_sup_link_fault       = sup_sink_en && (!idle_unequipped_container || ais || pointer_loss_condition
                                                    || trace_mismatch_raw);
      end else begin
        next_rx_bip_acc = rx_bip_acc ^ rx_byte;
      end
      case (rx_pos_now)
        PW'(spsu_pkg::POS_PARITY): begin
          next_local_err = 4'($countones(rx_byte ^ rx_bip_prev));
        end
        PW'(spsu_pkg::POS_LABEL): begin
          if (rx_byte == cand_label) begin
            if (cand_cnt < CW'(ACCEPT_N)) begin
              next_cand_cnt = cand_cnt + CW'(1);
            end
            if (cand_cnt >= CW'(ACCEPT_N - 1)) begin
              next_accepted_label = rx_byte;
            end
          end else begin
            next_cand_label = rx_byte;
            next_cand_cnt   = CW'(1);
          end
        end
        PW'(spsu_pkg::POS_STATUS): begin
          next_remote_defect_cause = rx_byte[spsu_pkg::STAT_RDI_BIT] && !idle_unequipped_container;
          next_fe_error_count      = idle_unequipped_container ? 4'h0 : rx_byte[7:4];
          next_fe_count_valid      = !idle_unequipped_container;
        end
        default: begin
          next_local_err = local_err;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rx_pos               <= POS_LAST;
      rx_bip_acc           <= 8'h00;
      rx_bip_prev          <= 8'h00;
      local_err            <= 4'h0;
      cand_label           <= 8'h00;
      cand_cnt             <= '0;
      accepted_label       <= 8'h00;
      unequipped_defect    <= 1'b0;
      label_mismatch       <= 1'b0;
      ais_detect           <= 1'b0;
      trace_mismatch_cause <= 1'b0;
      remote_defect_cause  <= 1'b0;
      fe_error_count       <= 4'h0;
      fe_count_valid       <= 1'b0;
      link_available       <= 1'b0;
      sup_link_fault       <= 1'b0;
    end else begin
      rx_pos               <= next_rx_pos;
      rx_bip_acc           <= next_rx_bip_acc;
      rx_bip_prev          <= next_rx_bip_prev;
      local_err            <= next_local_err;
      cand_label           <= next_cand_label;
      cand_cnt             <= next_cand_cnt;
      accepted_label       <= next_accepted_label;
      unequipped_defect    <= next_unequipped_defect;
      label_mismatch       <= next_label_mismatch;
      ais_detect           <= next_ais_detect;
      trace_mismatch_cause <= next_trace_mismatch_cause;
      remote_defect_cause  <= next_remote_defect_cause;
      fe_error_count       <= next_fe_error_count;
      fe_count_valid       <= next_fe_count_valid;
      link_available       <= next_link_available;
      sup_link_fault       <= next_sup_link_fault;
    end
  end

endmodule
`default_nettype wire

// ### tb/spsu_label_sup_sva.sv
// Purpose: Port-level checks for the label supervision block
// Assumes: Bound to spsu_label_sup, one clock, synchronous active-low reset
// Notes:   Flags refresh once per frame, so cause checks look at rising edges
`timescale 1ns/100ps
`default_nettype none
module spsu_label_sup_sva #(
  parameter int unsigned FRAME_LEN = 16
) (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        resetn,
  // Register read side
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // Transmit framing
  input wire logic        tx_frame_start,
  // Supervision status
  input wire logic [7:0]  accepted_label,
  input wire logic        unequipped_defect,
  input wire logic        label_mismatch,
  input wire logic        ais_detect,
  input wire logic        trace_mismatch_cause,
  input wire logic        remote_defect_cause,
  input wire logic        fe_count_valid,
  input wire logic        link_available
);
  localparam int FL = FRAME_LEN;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  // Read data only in the slot after a read strobe
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside read slot");
  // Idle container frames repeat at a fixed period
  AST_FRAME_PERIOD: assert property (tx_frame_start |-> ##FL tx_frame_start)
    else $error("transmit frame period wrong");
  // Unequipped raised only from an accepted zero label
  AST_IDLE_UNEQUIPPED_CONTAINER_CAUSE: assert property ($rose(unequipped_defect) |-> $past(accepted_label) == 8'h00)
    else $error("unequipped without zero label");
  // Zero label never doubles as a mismatch
  AST_IDLE_UNEQUIPPED_CONTAINER_NO_MISMATCH: assert property (unequipped_defect |-> !label_mismatch)
    else $error("mismatch while unequipped");
  // Trace cause hidden while unequipped
  AST_IDLE_UNEQUIPPED_CONTAINER_NO_TRACE: assert property (unequipped_defect |-> !trace_mismatch_cause)
    else $error("trace cause while unequipped");
  // Remote defect cause needs an equipped label
  AST_RDI_EQUIPPED: assert property ($rose(remote_defect_cause) |-> $past(accepted_label) != 8'h00)
    else $error("remote defect from unequipped signal");
  // Mismatch never from zero or the non-specific code
  AST_MISMATCH_CAUSE: assert property ($rose(label_mismatch) |->
    $past(accepted_label) != 8'h00 && $past(accepted_label) != 8'h01)
    else $error("mismatch on zero or wildcard label");
  // Far-end counts dropped while label is zero
  AST_FE_GATE: assert property (fe_count_valid |-> accepted_label != 8'h00)
    else $error("far-end count while unequipped");
  // Far-end count strobe lasts one cycle
  AST_FE_PULSE: assert property (fe_count_valid |=> !fe_count_valid)
    else $error("far-end strobe too long");
  // Link not available under alarm indication
  AST_LINK_AIS: assert property (link_available |-> !ais_detect)
    else $error("link available with alarm indication");
endmodule

bind spsu_label_sup spsu_label_sup_sva #(.FRAME_LEN(FRAME_LEN)) u_sva (
  .ref_clk(ref_clk), .resetn(resetn), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .tx_frame_start(tx_frame_start), .accepted_label(accepted_label),
  .unequipped_defect(unequipped_defect), .label_mismatch(label_mismatch),
  .ais_detect(ais_detect), .trace_mismatch_cause(trace_mismatch_cause),
  .remote_defect_cause(remote_defect_cause), .fe_count_valid(fe_count_valid),
  .link_available(link_available)
);
`default_nettype wire

// ### tb/spsu_far_src.sv
// Purpose: Remote termination and adaptation source feeding the receive side
// Assumes: 16-byte frames, one idle cycle between frames
// Notes:   Idle cycle shows the inverted byte so stale data cannot pass
`timescale 1ns/100ps
`default_nettype none
module spsu_far_src (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // Far-end settings
  input  wire logic [7:0] label,
  input  wire logic       rdi,
  // Receive stream
  output logic      [7:0] rx_byte,
  output logic            rx_valid,
  output logic            rx_frame_start
);
  logic [4:0] pos;
  logic [7:0] bip;
  logic [7:0] bip_prev;
  logic [7:0] b;

  // Overhead layout of the outgoing frame
  always_comb begin
    case (pos)
      5'h01:   b = bip_prev;
      5'h02:   b = label;
      5'h03:   b = {4'ha, rdi, 3'h0}; // Fixed far-end error count so the sink field is seen
      default: b = 8'h00;
    endcase
  end

  // Frame sequencer with a gap so rx_valid gets exercised
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pos            <= 5'h00;
      bip            <= 8'h00;
      bip_prev       <= 8'h00;
      rx_byte        <= 8'h00;
      rx_valid       <= 1'b0;
      rx_frame_start <= 1'b0;
    end else if (pos == 5'h10) begin
      pos            <= 5'h00;
      rx_byte        <= ~rx_byte;
      rx_valid       <= 1'b0;
      rx_frame_start <= 1'b0;
    end else begin
      pos            <= pos + 5'h01;
      rx_byte        <= b;
      rx_valid       <= 1'b1;
      rx_frame_start <= (pos == 5'h00);
      bip            <= (pos == 5'h00) ? b : (bip ^ b);
      if (pos == 5'h00) begin
        bip_prev <= bip;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/tb.sv
// Purpose: Self-checking bench for the label supervision block
// Assumes: Far source model drives the receive side
// Notes:   Label cases run from a table, transmit modes and resets by hand
`timescale 1ns/100ps
`default_nettype none
module tb;
  typedef struct {logic [7:0] lbl; logic [7:0] exp; logic [31:0] st;} spsu_row_s;
  logic        ref_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [5:0]  reg_addr = 6'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [7:0]  trf_byte = 8'h5a;
  logic [7:0]  far_label = 8'h00;
  logic        ploss = 1'b0;
  logic        tim_raw = 1'b1;
  logic [7:0]  tx_byte, rx_byte, accepted_label, x;
  logic        tx_frame_start, rx_valid, rx_frame_start, idle_unequipped_container, mism, ais, tmc, rdc, fev, link, slf;
  logic [3:0]  fe_error_count;
  logic [7:0]  cap [0:31];
  logic [31:0] rd;
  int          n_mismatch = 0;
  int          compares = 0;
  int          fe_cnt = 0;
  int          fe0;
  // Check field 0x09: header-only trace with an all-zero store, over x^7+x^3+1
  spsu_row_s   rows [5] = '{'{8'h00, 8'h01, 32'h0900_0042}, '{8'h01, 8'h05, 32'h0901_0070},
    '{8'h05, 8'h05, 32'h0905_0070}, '{8'h07, 8'h05, 32'h0907_0074}, '{8'hff, 8'h05, 32'h09ff_003c}};

  spsu_label_sup dut (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trf_byte(trf_byte), .tx_byte(tx_byte),
    .tx_frame_start(tx_frame_start), .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_frame_start(rx_frame_start),
    .pointer_loss_condition(ploss), .trace_mismatch_raw(tim_raw), .accepted_label(accepted_label),
    .unequipped_defect(idle_unequipped_container), .label_mismatch(mism), .ais_detect(ais), .trace_mismatch_cause(tmc),
    .remote_defect_cause(rdc), .fe_error_count(fe_error_count), .fe_count_valid(fev),
    .link_available(link), .sup_link_fault(slf));
  spsu_far_src u_far (.ref_clk(ref_clk), .resetn(resetn), .label(far_label), .rdi(1'b1),
    .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_frame_start(rx_frame_start));

  // 200 MHz clock and far-end count monitor
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (fev === 1'b1) fe_cnt++;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic reg_write(input logic [5:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data is taken in the single cycle it stands
  task automatic reg_read(input logic [5:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Two whole transmit frames from a frame start, bounded search
  task automatic tx_capture();
    int i;
    i = 0;
    @(posedge ref_clk);
    #1;
    while (tx_frame_start !== 1'b1 && i < 40) begin
      @(posedge ref_clk);
      #1 i++;
    end
    if (i >= 40) begin
      n_mismatch++;
      complete_run();
    end else begin
      for (int k = 0; k < 32; k++) begin
        cap[k] = tx_byte;
        @(posedge ref_clk);
        #1;
      end
    end
  endtask

  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge ref_clk);
    n_mismatch++;
    complete_run();
  end

  initial begin
    @(posedge ref_clk);
    #1 chk({tx_byte, accepted_label, idle_unequipped_container, mism, link, fev}, 32'h0);
    @(posedge ref_clk);
    resetn <= 1'b1;
    reg_read(spsu_pkg::ADDR_CTRL, rd);
    chk(rd, spsu_pkg::CTRL_RESET);
    reg_write(6'h3f, 32'hffff_ffff);
    reg_read(6'h3f, rd);
    chk(rd, 32'h0);
    reg_read(spsu_pkg::ADDR_TRACE, rd);
    chk(rd, 32'h0);
    reg_read(spsu_pkg::ADDR_CTRL, rd);
    chk(rd, spsu_pkg::CTRL_RESET);
    $display("test registers done");
    // Label table: acceptance, unequipped, wildcard, mismatch, alarm
    foreach (rows[r]) begin
      far_label <= rows[r].lbl;
      reg_write(spsu_pkg::ADDR_CTRL, {16'h0, rows[r].exp, 6'h0, spsu_pkg::MODE_IDLE});
      repeat (136) @(posedge ref_clk);
      #1 fe0 = fe_cnt;
      repeat (34) @(posedge ref_clk);
      reg_read(spsu_pkg::ADDR_STATUS, rd);
      chk(rd & 32'h7fff_007e, rows[r].st);
      chk({28'h0, fe_error_count}, (rows[r].lbl != 8'h00) ? 32'ha : 32'h0);
      chk({24'h0, accepted_label}, {24'h0, rows[r].lbl});
      chk({31'h0, fe_cnt != fe0}, {31'h0, rows[r].lbl != 8'h00});
    end
    $display("test label table done");
    // Transmit modes with pointer loss so remote defect is sent
    @(posedge ref_clk);
    far_label <= 8'h05;
    ploss     <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      reg_write(spsu_pkg::ADDR_CTRL, {15'h0, 1'b1, 8'h05, 6'h0, 2'(m)});
      repeat (40) @(posedge ref_clk);
      tx_capture();
      x = 8'h00;
      for (int k = 0; k < 16; k++) x ^= cap[k];
      if (m == 0) begin
        chk({24'h0, cap[8]}, 32'h5a);
      end else begin
        chk({24'h0, cap[17]}, {24'h0, x});
        chk({16'h0, cap[2], cap[4]}, 32'h0);
        if (m == 1) chk({16'h0, cap[0], cap[3]}, 32'h0);
        else chk({31'h0, cap[3][3]}, 32'h1);
      end
    end
    chk({30'h0, link, slf}, 32'h1);
    $display("test transmit modes done");
    // Second reset in mid-run, driven on clock edges
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 chk({accepted_label, idle_unequipped_container, mism, slf, link, fe_error_count}, 32'h0);
    @(posedge ref_clk);
    resetn <= 1'b1;
    reg_read(spsu_pkg::ADDR_CTRL, rd);
    chk(rd, spsu_pkg::CTRL_RESET);
    $display("test mid-run reset done");
    complete_run();
  end
endmodule
`default_nettype wire
